// ==== rtl/eamc_top.sv ====
/*
 * Energy accumulation mode configuration: APB register bank, power
 * contribution shaping, sign and fault event detection, gain decode,
 * zero-cross pin routing and a masked level interrupt.
 * Assumes power samples, pulse strobes, fault and zero-cross levels come
 * from metering logic on the same clock, so none are synchronised.
 */
// Local design decision: the APB slave port.
// Overview of operation
// - Accum mode bit 7 reads which current input feeds energy under tamper.
// - Bit 6 picks fault event: 0 on fault entry, 1 on return to normal.
// - Bit 5 picks reactive sign event: 0 positive-to-negative, 1 negative-to-positive.
// - Bit 4 picks active sign event: 0 positive-to-negative, 1 negative-to-positive.
// - Bit 3 set accumulates reactive power magnitude, sign ignored.
// - Bit 2 set inverts reactive power while active power is negative.
// - Sign adjustment applies to all reactive energy registers and pulse output.
// - Bit 1 set accumulates only positive active power, negatives dropped.
// - Bit 0 set accumulates active power magnitude, sign ignored.
// - Gain bits 7:5 set voltage gain; codes 0..4 give 1,2,4,8,16.
// - Gain bits 2:0 set current gain; codes 0..4 give 1,2,4,8,16.
// - Gain bit 3 picks sign detection on filtered power or per pulse.
// - Mode bit 1 routes zero-crossing indication to pin P1.2.
// - Mode bit 0 routes zero-crossing indication to pin P0.5.
// - Active sign flag, status bit 3, sets on the chosen active transition.
// - Fault flag, status bit 5, sets on the chosen fault transition.
`timescale 1ns/1ps
module eamc_top #(
    parameter int PW = 24
) (
    input wire logic I_CLOCK,
    input wire logic I_SYS_RST,
    input wire logic I_CLOCK_EN,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [eamc_pkg::ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_POWER_VALID,
    input wire logic signed [PW-1:0] I_ACTIVE_POWER,
    input wire logic signed [PW-1:0] I_REACTIVE_POWER,
    input wire logic I_ACTIVE_PULSE,
    input wire logic I_REACTIVE_PULSE,
    input wire logic I_FAULT_MODE,
    input wire logic I_TAMPER_INPUT_B,
    input wire logic I_ZERO_CROSS,
    output logic signed [PW:0] O_ACTIVE_CONTRIB,
    output logic signed [PW:0] O_REACTIVE_CONTRIB,
    output logic O_CONTRIB_VALID,
    output logic [4:0] O_VOLTAGE_GAIN,
    output logic [4:0] O_CURRENT_GAIN,
    output logic O_SIGN_DETECT_POINT,
    output logic O_ZX_P1_2,
    output logic O_ZX_P0_5,
    output logic O_IRQ
);
    // ==========================================================
    // Declarations
    logic [6:0] accum_mode_r;
    logic tamper_sel_r;
    logic [7:0] gain_r;
    logic [7:0] zx_mode_r;
    logic [7:0] irq_status_r;
    logic [7:0] irq_enable_r;
    logic [7:0] irq_set;
    logic [7:0] irq_clr;
    logic [7:0] rd_nxt;
    logic rd_hit;
    logic [7:0] idx;
    logic acc_done;
    logic wr_en;
    logic act_neg_r;
    logic react_neg_r;
    logic fault_prev_r;
    logic act_sample;
    logic react_sample;
    logic act_neg_now;
    logic react_neg_now;
    logic act_event;
    logic react_event;
    logic fault_event;
    logic signed [PW:0] act_ext;
    logic signed [PW:0] react_ext;
    logic signed [PW:0] act_nxt;
    logic signed [PW:0] react_nxt;

    // Every assertion runs on the core clock and pauses with the enable
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_SYS_RST || !I_CLOCK_EN);

    function automatic logic [4:0] gain_decode(input logic [2:0] code);
        logic [4:0] g;
        g = eamc_pkg::GAIN_UNITY;
        if (code <= eamc_pkg::GAIN_CODE_MAX)
        begin
            g = eamc_pkg::GAIN_UNITY << code;
        end
        return g;
    endfunction

    // ==========================================================
    // APB slave
    // One wait state so read data can leave a flip-flop
    assign idx = 8'(I_PADDR >> eamc_pkg::IDX_LSB);
    assign acc_done = I_PSEL && I_PENABLE && O_PREADY;
    assign wr_en = acc_done && I_PWRITE && I_CLOCK_EN;

    always_comb
    begin
        rd_nxt = eamc_pkg::REG_RESET;
        rd_hit = 1'b1;
        unique case (idx)
            eamc_pkg::IDX_ACCUM_MODE: rd_nxt = {tamper_sel_r, accum_mode_r};
            eamc_pkg::IDX_CHANNEL_GAIN: rd_nxt = gain_r;
            eamc_pkg::IDX_ZERO_CROSS_MODE: rd_nxt = zx_mode_r;
            eamc_pkg::IDX_IRQ_STATUS: rd_nxt = irq_status_r;
            eamc_pkg::IDX_IRQ_CLEAR: rd_nxt = eamc_pkg::REG_RESET;
            eamc_pkg::IDX_IRQ_ENABLE: rd_nxt = irq_enable_r;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge I_CLOCK)
    begin
        if (I_SYS_RST)
        begin
            O_PREADY <= 1'b0;
            O_PRDATA <= '0;
            O_PSLVERR <= 1'b0;
        end
        else if (I_CLOCK_EN)
        begin
            O_PREADY <= I_PSEL && I_PENABLE && !O_PREADY;
            O_PSLVERR <= I_PSEL && I_PENABLE && !O_PREADY && !rd_hit;
            O_PRDATA <= (I_PSEL && I_PENABLE && !O_PREADY && !I_PWRITE) ?
                        {24'h000000, rd_nxt} : 32'h00000000;
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge I_CLOCK)
    begin
        if (I_SYS_RST)
        begin
            accum_mode_r <= eamc_pkg::REG_RESET[6:0];
            gain_r <= eamc_pkg::REG_RESET;
            zx_mode_r <= eamc_pkg::REG_RESET;
            irq_enable_r <= eamc_pkg::REG_RESET;
        end
        else if (wr_en)
        begin
            unique case (idx)
                eamc_pkg::IDX_ACCUM_MODE:
                    accum_mode_r <= I_PWDATA[6:0] & eamc_pkg::AM_WR_MASK;
                eamc_pkg::IDX_CHANNEL_GAIN:
                    gain_r <= I_PWDATA[7:0] & eamc_pkg::GN_WR_MASK;
                eamc_pkg::IDX_ZERO_CROSS_MODE:
                    zx_mode_r <= I_PWDATA[7:0] & eamc_pkg::ZX_WR_MASK;
                eamc_pkg::IDX_IRQ_ENABLE:
                    irq_enable_r <= I_PWDATA[7:0] & eamc_pkg::IRQ_MASK;
                default:
                begin
                end
            endcase
        end
    end

    // Read-only tamper channel indication
    always_ff @(posedge I_CLOCK)
    begin
        if (I_SYS_RST)
        begin
            tamper_sel_r <= 1'b0;
        end
        else if (I_CLOCK_EN)
        begin
            tamper_sel_r <= I_TAMPER_INPUT_B;
        end
    end

    // ==========================================================
    // Gain decode and zero-cross routing
    always_ff @(posedge I_CLOCK)
    begin
        if (I_SYS_RST)
        begin
            O_VOLTAGE_GAIN <= eamc_pkg::GAIN_UNITY;
            O_CURRENT_GAIN <= eamc_pkg::GAIN_UNITY;
            O_SIGN_DETECT_POINT <= 1'b0;
            O_ZX_P1_2 <= 1'b0;
            O_ZX_P0_5 <= 1'b0;
        end
        else if (I_CLOCK_EN)
        begin
            // Undefined codes fall back to unity
            O_VOLTAGE_GAIN <= gain_decode(
                gain_r[eamc_pkg::GN_VOLT_MSB:eamc_pkg::GN_VOLT_LSB]);
            O_CURRENT_GAIN <= gain_decode(
                gain_r[eamc_pkg::GN_CURR_MSB:eamc_pkg::GN_CURR_LSB]);
            O_SIGN_DETECT_POINT <= gain_r[eamc_pkg::GN_SIGN_POINT];
            O_ZX_P1_2 <= zx_mode_r[eamc_pkg::ZX_OUT_A] && I_ZERO_CROSS;
            O_ZX_P0_5 <= zx_mode_r[eamc_pkg::ZX_OUT_B] && I_ZERO_CROSS;
        end
    end

    // ==========================================================
    // Contribution shaping
    // One extra bit so the magnitude of the most negative sample fits
    assign act_ext = {I_ACTIVE_POWER[PW-1], I_ACTIVE_POWER};
    assign react_ext = {I_REACTIVE_POWER[PW-1], I_REACTIVE_POWER};

    always_comb
    begin
        act_nxt = act_ext;
        if (accum_mode_r[eamc_pkg::AM_ACT_MAG] && act_ext < 0)
        begin
            act_nxt = -act_ext;
        end
        else if (accum_mode_r[eamc_pkg::AM_ACT_POS_ONLY] && act_ext < 0)
        begin
            act_nxt = '0;
        end
        react_nxt = react_ext;
        // Magnitude mode overrides sign adjustment when both are set
        if (accum_mode_r[eamc_pkg::AM_REACT_MAG] && react_ext < 0)
        begin
            react_nxt = -react_ext;
        end
        else if (!accum_mode_r[eamc_pkg::AM_REACT_MAG] &&
                 accum_mode_r[eamc_pkg::AM_REACT_SADJ] && act_ext < 0)
        begin
            react_nxt = -react_ext;
        end
    end

    // Single shaped value feeds every reactive register and pulse path
    always_ff @(posedge I_CLOCK)
    begin
        if (I_SYS_RST)
        begin
            O_ACTIVE_CONTRIB <= '0;
            O_REACTIVE_CONTRIB <= '0;
            O_CONTRIB_VALID <= 1'b0;
        end
        else if (I_CLOCK_EN)
        begin
            O_CONTRIB_VALID <= I_POWER_VALID;
            if (I_POWER_VALID)
            begin
                O_ACTIVE_CONTRIB <= act_nxt;
                O_REACTIVE_CONTRIB <= react_nxt;
            end
        end
    end

    // ==========================================================
    // Sign and fault event detection
    assign act_sample = gain_r[eamc_pkg::GN_SIGN_POINT] ? I_ACTIVE_PULSE
                                                        : I_POWER_VALID;
    assign react_sample = gain_r[eamc_pkg::GN_SIGN_POINT] ? I_REACTIVE_PULSE
                                                          : I_POWER_VALID;
    assign act_neg_now = I_ACTIVE_POWER[PW-1];
    assign react_neg_now = I_REACTIVE_POWER[PW-1];
    assign act_event = act_sample && (act_neg_now != act_neg_r) &&
        (act_neg_now != accum_mode_r[eamc_pkg::AM_ACT_SIGN_SEL]);
    assign react_event = react_sample && (react_neg_now != react_neg_r) &&
        (react_neg_now != accum_mode_r[eamc_pkg::AM_REACT_SIGN_SEL]);
    assign fault_event = (I_FAULT_MODE != fault_prev_r) &&
        (I_FAULT_MODE != accum_mode_r[eamc_pkg::AM_FAULT_SEL]);

    always_ff @(posedge I_CLOCK)
    begin
        if (I_SYS_RST)
        begin
            act_neg_r <= 1'b0;
            react_neg_r <= 1'b0;
            fault_prev_r <= 1'b0;
        end
        else if (I_CLOCK_EN)
        begin
            fault_prev_r <= I_FAULT_MODE;
            if (act_sample)
            begin
                act_neg_r <= act_neg_now;
            end
            if (react_sample)
            begin
                react_neg_r <= react_neg_now;
            end
        end
    end

    // ==========================================================
    // Interrupt status, clear and output
    // A set in the clearing cycle wins so no event is lost
    always_comb
    begin
        irq_set = '0;
        irq_set[eamc_pkg::IRQ_ACT_SIGN] = act_event;
        irq_set[eamc_pkg::IRQ_REACT_SIGN] = react_event;
        irq_set[eamc_pkg::IRQ_FAULT] = fault_event;
        irq_clr = '0;
        if (wr_en && idx == eamc_pkg::IDX_IRQ_CLEAR)
        begin
            irq_clr = I_PWDATA[7:0] & eamc_pkg::IRQ_MASK;
        end
    end

    always_ff @(posedge I_CLOCK)
    begin
        if (I_SYS_RST)
        begin
            irq_status_r <= eamc_pkg::REG_RESET;
            O_IRQ <= 1'b0;
        end
        else if (I_CLOCK_EN)
        begin
            irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
            O_IRQ <= |(irq_status_r & irq_enable_r);
        end
    end

    // ==========================================================
    // Assertions
    a_tamper_readback: assert property (
        I_PSEL && I_PENABLE && !O_PREADY && !I_PWRITE && idx == eamc_pkg::IDX_ACCUM_MODE
        |=> O_PRDATA[eamc_pkg::AM_TAMPER_SEL] == $past(tamper_sel_r))
        else $error("tamper channel bit reads wrong");
    a_fault_event_dir: assert property (
        $rose(I_FAULT_MODE) && !accum_mode_r[eamc_pkg::AM_FAULT_SEL]
        |=> irq_status_r[eamc_pkg::IRQ_FAULT])
        else $error("fault entry did not flag");
    a_fault_no_event: assert property (
        !fault_event && !irq_status_r[eamc_pkg::IRQ_FAULT]
        |=> !irq_status_r[eamc_pkg::IRQ_FAULT])
        else $error("fault flag set without event");
    a_react_sign_dir: assert property (
        react_event |-> react_neg_now == !accum_mode_r[eamc_pkg::AM_REACT_SIGN_SEL]
        ##1 irq_status_r[eamc_pkg::IRQ_REACT_SIGN])
        else $error("reactive sign event wrong");
    a_act_sign_flag: assert property (
        act_sample && act_neg_r && !act_neg_now && accum_mode_r[eamc_pkg::AM_ACT_SIGN_SEL]
        |=> irq_status_r[eamc_pkg::IRQ_ACT_SIGN])
        else $error("active negative-to-positive missed");
    a_react_magnitude: assert property (
        I_POWER_VALID && accum_mode_r[eamc_pkg::AM_REACT_MAG]
        |=> O_REACTIVE_CONTRIB >= 0)
        else $error("reactive magnitude negative");
    a_react_sign_adj: assert property (
        I_POWER_VALID && accum_mode_r[eamc_pkg::AM_REACT_SADJ] &&
        !accum_mode_r[eamc_pkg::AM_REACT_MAG] && act_ext < 0
        |=> O_REACTIVE_CONTRIB == -$past(react_ext))
        else $error("reactive not inverted");
    a_act_pos_only: assert property (
        I_POWER_VALID && accum_mode_r[eamc_pkg::AM_ACT_POS_ONLY]
        |=> O_ACTIVE_CONTRIB >= 0)
        else $error("negative active kept");
    a_act_magnitude: assert property (
        I_POWER_VALID && accum_mode_r[eamc_pkg::AM_ACT_MAG]
        |=> O_ACTIVE_CONTRIB == ($past(act_ext) < 0 ? -$past(act_ext) : $past(act_ext)))
        else $error("active magnitude wrong");
    a_volt_gain: assert property (
        gain_r[eamc_pkg::GN_VOLT_MSB:eamc_pkg::GN_VOLT_LSB] > eamc_pkg::GAIN_CODE_MAX
        ##1 $stable(gain_r) |-> O_VOLTAGE_GAIN == eamc_pkg::GAIN_UNITY)
        else $error("voltage gain not unity");
    a_curr_gain: assert property (
        $stable(gain_r) [*2] |-> O_CURRENT_GAIN ==
        ((gain_r[eamc_pkg::GN_CURR_MSB:eamc_pkg::GN_CURR_LSB] > eamc_pkg::GAIN_CODE_MAX) ?
        eamc_pkg::GAIN_UNITY :
        5'(eamc_pkg::GAIN_UNITY << gain_r[eamc_pkg::GN_CURR_MSB:eamc_pkg::GN_CURR_LSB])))
        else $error("current gain does not match its code");
    a_zx_route: assert property (
        !zx_mode_r[eamc_pkg::ZX_OUT_A] |=> !O_ZX_P1_2)
        else $error("zero-cross on P1.2 while disabled");
    a_zx_route_b: assert property (
        zx_mode_r[eamc_pkg::ZX_OUT_B] && I_ZERO_CROSS |=> O_ZX_P0_5)
        else $error("zero-cross missing on P0.5");
endmodule // eamc_top

// ==== shared/eamc_pkg.sv ====
/*
 * Constants of the energy accumulation mode configuration block:
 * register indices, field positions, reset values and gain codes.
 * Assumes a 32-bit APB in which register index n sits at byte address 4*n.
 */
package eamc_pkg;
    // ==========================================================
    // Register indices and byte addresses
    localparam logic [7:0] IDX_ACCUM_MODE = 8'h0F;
    localparam logic [7:0] IDX_CHANNEL_GAIN = 8'h1B;
    localparam logic [7:0] IDX_ZERO_CROSS_MODE = 8'h2B;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h31;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h32;
    localparam int ADDR_W = 10;
    localparam int IDX_LSB = 2;
    // ==========================================================
    // Accumulation mode fields
    localparam int AM_TAMPER_SEL = 7;
    localparam int AM_FAULT_SEL = 6;
    localparam int AM_REACT_SIGN_SEL = 5;
    localparam int AM_ACT_SIGN_SEL = 4;
    localparam int AM_REACT_MAG = 3;
    localparam int AM_REACT_SADJ = 2;
    localparam int AM_ACT_POS_ONLY = 1;
    localparam int AM_ACT_MAG = 0;
    localparam logic [6:0] AM_WR_MASK = 7'h7F;
    // ==========================================================
    // Gain fields
    localparam int GN_VOLT_MSB = 7;
    localparam int GN_VOLT_LSB = 5;
    localparam int GN_SIGN_POINT = 3;
    localparam int GN_CURR_MSB = 2;
    localparam int GN_CURR_LSB = 0;
    localparam logic [7:0] GN_WR_MASK = 8'hEF;
    localparam logic [2:0] GAIN_CODE_MAX = 3'h4;
    localparam logic [4:0] GAIN_UNITY = 5'h01;
    // ==========================================================
    // Zero-cross output mode fields
    localparam int ZX_OUT_A = 1;
    localparam int ZX_OUT_B = 0;
    localparam logic [7:0] ZX_WR_MASK = 8'h03;
    // ==========================================================
    // Interrupt status layout
    localparam int IRQ_ACT_SIGN = 3;
    localparam int IRQ_REACT_SIGN = 4;
    localparam int IRQ_FAULT = 5;
    localparam logic [7:0] IRQ_MASK = 8'h38;
    // ==========================================================
    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;
endpackage

// ==== verif/energy_accum_mode_config_tb.sv ====
/*
 * Self-checking bench of the accumulation mode configuration block.
 * Assumes the eamc_pkg package and eamc_top compiled first; one 100 MHz clock.
 */
`timescale 1ns/1ps
module energy_accum_mode_config_tb;
    // ==========================================================
    // Stimulus and design
    logic I_CLOCK = 1'b0;
    logic I_SYS_RST = 1'b1;
    logic I_CLOCK_EN = 1'b1;
    logic I_PSEL = 1'b0;
    logic I_PENABLE = 1'b0;
    logic I_PWRITE = 1'b0;
    logic [9:0] I_PADDR = 10'h000;
    logic [31:0] I_PWDATA = 32'h00000000;
    logic I_POWER_VALID = 1'b0;
    logic signed [23:0] I_ACTIVE_POWER = 24'sh000000;
    logic signed [23:0] I_REACTIVE_POWER = 24'sh000000;
    logic I_ACTIVE_PULSE = 1'b0;
    logic I_REACTIVE_PULSE = 1'b0;
    logic I_FAULT_MODE = 1'b0;
    logic I_TAMPER_INPUT_B = 1'b0;
    logic I_ZERO_CROSS = 1'b0;
    logic [31:0] O_PRDATA;
    logic O_PREADY, O_PSLVERR, O_CONTRIB_VALID, O_SIGN_DETECT_POINT;
    logic signed [24:0] O_ACTIVE_CONTRIB, O_REACTIVE_CONTRIB;
    logic [4:0] O_VOLTAGE_GAIN, O_CURRENT_GAIN;
    logic O_ZX_P1_2, O_ZX_P0_5, O_IRQ;
    int errors = 0;
    int compares = 0;

    initial
    begin
        forever #5 I_CLOCK = ~I_CLOCK;
    end

    eamc_top DUT (.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_CLOCK_EN(I_CLOCK_EN),
        .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
        .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
        .O_PSLVERR(O_PSLVERR), .I_POWER_VALID(I_POWER_VALID),
        .I_ACTIVE_POWER(I_ACTIVE_POWER), .I_REACTIVE_POWER(I_REACTIVE_POWER),
        .I_ACTIVE_PULSE(I_ACTIVE_PULSE), .I_REACTIVE_PULSE(I_REACTIVE_PULSE),
        .I_FAULT_MODE(I_FAULT_MODE), .I_TAMPER_INPUT_B(I_TAMPER_INPUT_B),
        .I_ZERO_CROSS(I_ZERO_CROSS), .O_ACTIVE_CONTRIB(O_ACTIVE_CONTRIB),
        .O_REACTIVE_CONTRIB(O_REACTIVE_CONTRIB), .O_CONTRIB_VALID(O_CONTRIB_VALID),
        .O_VOLTAGE_GAIN(O_VOLTAGE_GAIN), .O_CURRENT_GAIN(O_CURRENT_GAIN),
        .O_SIGN_DETECT_POINT(O_SIGN_DETECT_POINT), .O_ZX_P1_2(O_ZX_P1_2),
        .O_ZX_P0_5(O_ZX_P0_5), .O_IRQ(O_IRQ));

    // ==========================================================
    // Shared tasks
    task automatic finish_test();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Request held until the rising edge that samples ready; data taken there
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge I_CLOCK);
        I_PSEL <= 1'b1;
        I_PENABLE <= 1'b0;
        I_PWRITE <= w;
        I_PADDR <= {idx, 2'b00};
        I_PWDATA <= wd;
        @(posedge I_CLOCK);
        I_PENABLE <= 1'b1;
        do
        begin
            @(posedge I_CLOCK);
            n++;
        end
        while (O_PREADY !== 1'b1 && n < 20);
        if (O_PREADY !== 1'b1)
        begin
            errors++;
            $display("[ERR] apb_ready expected 1 seen timeout");
            finish_test();
        end
        rd = O_PRDATA;
        err = O_PSLVERR;
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] v;
        logic e;
        apb(1'b1, idx, d, v, e);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] v);
        logic e;
        apb(1'b0, idx, 32'h00000000, v, e);
    endtask

    task automatic do_reset();
        @(posedge I_CLOCK);
        I_SYS_RST <= 1'b1;
        repeat (6) @(posedge I_CLOCK);
        I_SYS_RST <= 1'b0;
    endtask

    task automatic pwr(input logic signed [23:0] a, input logic signed [23:0] r);
        @(posedge I_CLOCK);
        I_POWER_VALID <= 1'b1;
        I_ACTIVE_POWER <= a;
        I_REACTIVE_POWER <= r;
        @(posedge I_CLOCK);
        I_POWER_VALID <= 1'b0;
        @(negedge I_CLOCK);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] v;
        logic e;
        do_reset();
        rd(eamc_pkg::IDX_ACCUM_MODE, v);
        check("accum_rst", v, 32'h00000000);
        check("vgain_rst", O_VOLTAGE_GAIN, 32'h00000001);
        wr(eamc_pkg::IDX_ACCUM_MODE, 32'hFFFFFFFF);
        rd(eamc_pkg::IDX_ACCUM_MODE, v);
        check("accum_ro_bit", v, 32'h0000007F);
        @(posedge I_CLOCK);
        I_TAMPER_INPUT_B <= 1'b1;
        rd(eamc_pkg::IDX_ACCUM_MODE, v);
        check("accum_tamper", v, 32'h000000FF);
        wr(eamc_pkg::IDX_CHANNEL_GAIN, 32'hFFFFFFFF);
        rd(eamc_pkg::IDX_CHANNEL_GAIN, v);
        check("gain_rsvd", v, 32'h000000EF);
        wr(eamc_pkg::IDX_ZERO_CROSS_MODE, 32'hFFFFFFFF);
        rd(eamc_pkg::IDX_ZERO_CROSS_MODE, v);
        check("zx_rsvd", v, 32'h00000003);
        apb(1'b0, 8'hFF, 32'h00000000, v, e);
        check("unmapped_err", e, 32'h00000001);
        check("unmapped_data", v, 32'h00000000);
        I_TAMPER_INPUT_B <= 1'b0;
    endtask

    task automatic t_gain();
        logic [2:0] c;
        logic [4:0] g;
        do_reset();
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:0];
            wr(eamc_pkg::IDX_CHANNEL_GAIN, {24'h000000, c, 1'b0, c[0], ~c});
            // Gain outputs follow the register one edge after the write
            repeat (2) @(negedge I_CLOCK);
            g = (c <= 3'h4) ? (5'h01 << c) : 5'h01;
            check("volt_gain", O_VOLTAGE_GAIN, g);
            g = (~c <= 3'h4) ? (5'h01 << ~c) : 5'h01;
            check("curr_gain", O_CURRENT_GAIN, g);
            check("sign_point", O_SIGN_DETECT_POINT, c[0]);
        end
    endtask

    task automatic t_shape();
        logic [7:0] modes [5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08};
        logic signed [24:0] ea, er;
        logic signed [23:0] a, r;
        do_reset();
        foreach (modes[m])
        begin
            wr(eamc_pkg::IDX_ACCUM_MODE, {24'h000000, modes[m]});
            for (int s = 0; s < 3; s++)
            begin
                a = (s == 0) ? 24'sd100 : -24'sd100;
                r = (s == 1) ? 24'sd50 : -24'sd50;
                ea = a;
                er = r;
                if (modes[m][0])
                    ea = (a < 0) ? -ea : ea;
                else if (modes[m][1] && a < 0)
                    ea = 25'sd0;
                if (modes[m][3])
                    er = (r < 0) ? -er : er;
                else if (modes[m][2] && a < 0)
                    er = -er;
                pwr(a, r);
                check("contrib_valid", O_CONTRIB_VALID, 32'h00000001);
                check("act_contrib", O_ACTIVE_CONTRIB, ea);
                check("react_contrib", O_REACTIVE_CONTRIB, er);
            end
        end
    endtask

    task automatic stim(input int k, input logic bad);
        if (k == 2)
        begin
            @(posedge I_CLOCK);
            I_FAULT_MODE <= bad;
            repeat (2) @(posedge I_CLOCK);
        end
        else if (k == 0)
            pwr(bad ? -24'sd40 : 24'sd40, 24'sd10);
        else
            pwr(24'sd10, bad ? -24'sd40 : 24'sd40);
    endtask

    // Kinds: 0 active sign, 1 reactive sign, 2 fault
    task automatic t_event(input int k, input logic sel);
        logic [31:0] v, b;
        b = 32'h00000001 << (3 + k);
        do_reset();
        wr(eamc_pkg::IDX_IRQ_ENABLE, 32'h00000038);
        wr(eamc_pkg::IDX_ACCUM_MODE, sel ? (32'h00000001 << (4 + k)) : 32'h00000000);
        stim(k, 1'b1);
        rd(eamc_pkg::IDX_IRQ_STATUS, v);
        check("status_bad", v, sel ? 32'h00000000 : b);
        check("irq_bad", O_IRQ, !sel);
        stim(k, 1'b0);
        rd(eamc_pkg::IDX_IRQ_STATUS, v);
        check("status_good", v, b);
        wr(eamc_pkg::IDX_IRQ_ENABLE, 32'h00000000);
        repeat (2) @(negedge I_CLOCK);
        check("irq_masked", O_IRQ, 32'h00000000);
        wr(eamc_pkg::IDX_IRQ_CLEAR, b);
        rd(eamc_pkg::IDX_IRQ_STATUS, v);
        check("status_clr", v, 32'h00000000);
    endtask

    // Per-pulse detection ignores filtered samples
    task automatic t_pulse();
        logic [31:0] v;
        do_reset();
        wr(eamc_pkg::IDX_CHANNEL_GAIN, 32'h00000008);
        pwr(-24'sd40, -24'sd10);
        rd(eamc_pkg::IDX_IRQ_STATUS, v);
        check("pulse_no_evt", v, 32'h00000000);
        @(posedge I_CLOCK);
        I_ACTIVE_PULSE <= 1'b1;
        I_REACTIVE_PULSE <= 1'b1;
        @(posedge I_CLOCK);
        I_ACTIVE_PULSE <= 1'b0;
        I_REACTIVE_PULSE <= 1'b0;
        rd(eamc_pkg::IDX_IRQ_STATUS, v);
        check("pulse_evt", v, 32'h00000018);
    endtask

    // Enable low freezes shaping and event flags
    task automatic t_hold();
        logic [31:0] v;
        do_reset();
        @(posedge I_CLOCK);
        I_CLOCK_EN <= 1'b0;
        pwr(-24'sd7, -24'sd7);
        check("hold_valid", O_CONTRIB_VALID, 32'h00000000);
        check("hold_contrib", O_ACTIVE_CONTRIB, 32'h00000000);
        @(posedge I_CLOCK);
        I_CLOCK_EN <= 1'b1;
        rd(eamc_pkg::IDX_IRQ_STATUS, v);
        check("hold_status", v, 32'h00000000);
    endtask

    task automatic t_zx();
        logic [1:0] z;
        do_reset();
        for (int i = 0; i < 4; i++)
        begin
            z = i[1:0];
            wr(eamc_pkg::IDX_ZERO_CROSS_MODE, {30'h00000000, z});
            I_ZERO_CROSS <= 1'b1;
            repeat (2) @(negedge I_CLOCK);
            check("zx_p1_2", O_ZX_P1_2, z[1]);
            check("zx_p0_5", O_ZX_P0_5, z[0]);
            @(posedge I_CLOCK);
            I_ZERO_CROSS <= 1'b0;
            repeat (2) @(negedge I_CLOCK);
            check("zx_idle", {O_ZX_P1_2, O_ZX_P0_5}, 32'h00000000);
        end
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        t_regs();
        t_gain();
        t_shape();
        for (int k = 0; k < 3; k++)
        begin
            t_event(k, 1'b0);
            t_event(k, 1'b1);
        end
        t_pulse();
        t_zx();
        t_hold();
        finish_test();
    end
endmodule // energy_accum_mode_config_tb
